//--- ravr_alarm_regs.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1 - Weekday/hour bits 15:11, 7:6 read zero
// RULE2 - Weekday field bits 10:8, values 0-6
// RULE3 - Hour tens bits 5:4, values 0-2
// RULE4 - Hour ones bits 3:0, values 0-9
// RULE5 - Day tens bits 5:4, values 0-3
// RULE6 - Day ones bits 3:0, values 0-9
// RULE7 - Month tens bit 12, ones 11:8
// RULE8 - Alarm writes only while write-enable set
// RULE9 - Month/day bits 15:13, 7:6 read zero
// RULE10 - Alarm fields start with undefined contents; here reset loads them with zero
module ravr_alarm_regs
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire ravr_pkg::ravr_alarm_t CAL_NOW,
	output ravr_pkg::ravr_alarm_t ALARM_VALUE,
	output logic CLOCK_WRITE_ENABLE,
	output logic ALARM_MATCH
);
	import ravr_pkg::*;

	// All registered state of the block, one struct
	ravr_state_t st_r;
	ravr_state_t st_nxt;

	// Bus phase decode
	logic setup_w;
	logic complete_w;
	logic write_w;

	// Register image of the month/day alarm, unimplemented bits low
	function automatic logic [15:0] md_word(input ravr_month_day_t m);
		md_word = {3'h0, m.month_tens_digit, m.month_ones_digit,
			2'h0, m.day_tens_digit, m.day_ones_digit}; // RULE7 RULE5 RULE6 RULE9
	endfunction : md_word

	// Register image of the weekday/hour alarm, unimplemented bits low
	function automatic logic [15:0] wh_word(input ravr_weekday_hour_t w);
		wh_word = {5'h00, w.weekday_digit, 2'h0,
			w.hour_tens_digit, w.hour_ones_digit}; // RULE1 RULE2 RULE3 RULE4
	endfunction : wh_word

	// Month/day fields out of a bus word
	function automatic ravr_month_day_t md_fields(input logic [15:0] v);
		ravr_month_day_t r;
		r.month_tens_digit = v[12]; // RULE7
		r.month_ones_digit = v[11:8]; // RULE7
		r.day_tens_digit = v[5:4]; // RULE5
		r.day_ones_digit = v[3:0]; // RULE6
		return r;
	endfunction : md_fields

	// Weekday/hour fields out of a bus word
	function automatic ravr_weekday_hour_t wh_fields(input logic [15:0] v);
		ravr_weekday_hour_t r;
		r.weekday_digit = v[10:8]; // RULE2
		r.hour_tens_digit = v[5:4]; // RULE3
		r.hour_ones_digit = v[3:0]; // RULE4
		return r;
	endfunction : wh_fields

	// Byte lanes enabled by the low two strobes
	function automatic logic [15:0] lane_mask(input logic [3:0] s);
		return {{8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	// Lanes not strobed keep their stored contents
	function automatic logic [15:0] merge_word(
		input logic [15:0] old_w,
		input logic [15:0] new_w,
		input logic [3:0] s
	);
		logic [15:0] m;
		m = lane_mask(s);
		return (old_w & ~m) | (new_w & m);
	endfunction : merge_word

	function automatic logic is_alarm_reg(input logic [11:0] a);
		return (a == OFS_MONTH_DAY) || (a == OFS_WEEKDAY_HOUR);
	endfunction : is_alarm_reg

	function automatic logic is_mapped(input logic [11:0] a);
		return is_alarm_reg(a) || (a == OFS_CONTROL) || (a == OFS_STATUS);
	endfunction : is_mapped

	// Match needs every digit field equal
	function automatic logic alarm_equal(input ravr_alarm_t a, input ravr_alarm_t b);
		logic eq_md;
		logic eq_wh;
		eq_md = (a.month_day == b.month_day);
		eq_wh = (a.weekday_hour == b.weekday_hour);
		return eq_md && eq_wh;
	endfunction : alarm_equal

	// Read image of any register; unmapped offsets read zero
	function automatic logic [31:0] read_word(
		input logic [11:0] a,
		input ravr_state_t s
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			OFS_MONTH_DAY:
				r[15:0] = md_word(s.alarm.month_day); // RULE9
			OFS_WEEKDAY_HOUR:
				r[15:0] = wh_word(s.alarm.weekday_hour); // RULE1
			OFS_CONTROL:
				r[CTL_WREN_BIT] = s.clock_write_enable;
			OFS_STATUS:
			begin
				r[STS_WREN_BIT] = s.clock_write_enable;
				r[STS_REFUSED_BIT] = s.refused;
				r[STS_MATCH_BIT] = s.match;
			end
			default:
				r = 32'h0000_0000;
		endcase
		return r;
	endfunction : read_word

	assign setup_w = PSEL && !PENABLE;
	// Ready registered in setup marks the completing edge of the access
	assign complete_w = PSEL && PENABLE && st_r.pready;
	// Unmapped offsets were flagged in setup, so their writes are dropped
	assign write_w = complete_w && PWRITE && !st_r.pslverr;

	always_comb
	begin
		logic [15:0] wd;
		logic [15:0] merged;
		wd = PWDATA[15:0];
		merged = 16'h0000;
		st_nxt = st_r;
		// Ready and error stand for exactly one cycle
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		// Answer one cycle after setup, so the access phase never waits
		if (setup_w)
		begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = !is_mapped(PADDR);
			st_nxt.prdata = read_word(PADDR, st_r);
		end
		// Write takes effect at the completing edge of the access phase
		if (write_w)
		begin
			unique case (PADDR)
				OFS_MONTH_DAY:
				begin
					if (st_r.clock_write_enable) // RULE8
					begin
						merged = merge_word(md_word(st_r.alarm.month_day),
							wd, PSTRB);
						st_nxt.alarm.month_day = md_fields(merged & MASK_MONTH_DAY); // RULE9
					end
					else
						st_nxt.refused = 1'b1; // RULE8
				end
				OFS_WEEKDAY_HOUR:
				begin
					if (st_r.clock_write_enable) // RULE8
					begin
						merged = merge_word(wh_word(st_r.alarm.weekday_hour),
							wd, PSTRB);
						st_nxt.alarm.weekday_hour = wh_fields(merged & MASK_WEEKDAY_HOUR); // RULE1
					end
					else
						st_nxt.refused = 1'b1; // RULE8
				end
				OFS_CONTROL:
				begin
					if (PSTRB[0])
						st_nxt.clock_write_enable = PWDATA[CTL_WREN_BIT];
				end
				OFS_STATUS:
				begin
					// Write one to clear; no alarm write lands in the same cycle
					if (PSTRB[0] && PWDATA[STS_REFUSED_BIT])
						st_nxt.refused = 1'b0;
				end
				default:
					st_nxt.refused = st_r.refused;
			endcase
		end
		// Calendar shares this clock, so no synchroniser is needed
		st_nxt.match = alarm_equal(CAL_NOW, st_r.alarm); // RULE2 RULE7
	end

	// Alarm fields reset to zero only so simulation is defined;
	// software must still load them before trusting the match
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			st_r <= '0; // RULE10
		else
			st_r <= st_nxt;
	end

	// Every output comes straight from the state register
	assign PRDATA = st_r.prdata;
	assign PREADY = st_r.pready;
	assign PSLVERR = st_r.pslverr;

	assign ALARM_VALUE = st_r.alarm;
	assign CLOCK_WRITE_ENABLE = st_r.clock_write_enable;

	// Match lags the calendar by one cycle
	assign ALARM_MATCH = st_r.match; // RULE2 RULE7

endmodule : ravr_alarm_regs

//--- ravr_pkg.sv
package ravr_pkg;

	// Byte offsets on the register bus
	localparam logic [11:0] OFS_MONTH_DAY = 12'h000;
	localparam logic [11:0] OFS_WEEKDAY_HOUR = 12'h004;
	localparam logic [11:0] OFS_CONTROL = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;

	// Implemented-bit masks of the two alarm registers
	localparam logic [15:0] MASK_MONTH_DAY = 16'h1f3f;
	localparam logic [15:0] MASK_WEEKDAY_HOUR = 16'h073f;

	// Control register: write-enable bit position
	localparam int CTL_WREN_BIT = 0;

	// Status register bit positions
	localparam int STS_WREN_BIT = 0;
	localparam int STS_REFUSED_BIT = 1;
	localparam int STS_MATCH_BIT = 2;

	// Legal digit limits
	localparam logic [3:0] MAX_ONES = 4'h9;
	localparam logic [1:0] MAX_HOUR_TENS = 2'h2;
	localparam logic [1:0] MAX_DAY_TENS = 2'h3;
	localparam logic [2:0] MAX_WEEKDAY = 3'h6;

	typedef struct packed {
		logic month_tens_digit;
		logic [3:0] month_ones_digit;
		logic [1:0] day_tens_digit;
		logic [3:0] day_ones_digit;
	} ravr_month_day_t;

	typedef struct packed {
		logic [2:0] weekday_digit;
		logic [1:0] hour_tens_digit;
		logic [3:0] hour_ones_digit;
	} ravr_weekday_hour_t;

	typedef struct packed {
		ravr_month_day_t month_day;
		ravr_weekday_hour_t weekday_hour;
	} ravr_alarm_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic clock_write_enable;
		logic refused;
		logic match;
		ravr_alarm_t alarm;
	} ravr_state_t;

endpackage : ravr_pkg

//--- ravr_alarm_regs_props.sv
`timescale 1ns/10ps
module ravr_alarm_regs_props
import ravr_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire ravr_alarm_t ALARM_VALUE,
	input wire logic CLOCK_WRITE_ENABLE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	wire acc = PSEL && PENABLE && PREADY;
	wire md = PADDR == OFS_MONTH_DAY;
	wire wh = PADDR == OFS_WEEKDAY_HOUR;
	wire wen = acc && PWRITE && CLOCK_WRITE_ENABLE && PSTRB == 4'h3;
	a_ready_one: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
	a_md_pad: assert property (acc && !PWRITE && md |-> PRDATA[31:13] == 19'h0 && PRDATA[7:6] == 2'h0)
		else $error("md pad");
	a_wh_pad: assert property (acc && !PWRITE && wh |-> PRDATA[31:11] == 21'h0 && PRDATA[7:6] == 2'h0)
		else $error("wh pad");
	a_wr_locked: assert property (acc && PWRITE && !CLOCK_WRITE_ENABLE |=> $stable(ALARM_VALUE))
		else $error("locked write");
	a_md_write: assert property (wen && md |=> ALARM_VALUE.month_day == {$past(PWDATA[12:8]),
		$past(PWDATA[5:0])}) else $error("md write");
	a_wh_write: assert property (wen && wh |=> ALARM_VALUE.weekday_hour == {$past(PWDATA[10:8]),
		$past(PWDATA[5:0])}) else $error("wh write");
	a_md_read: assert property (acc && !PWRITE && md |-> PRDATA[12:8] == ALARM_VALUE[19:15])
		else $error("md read");
	a_wh_read: assert property (acc && !PWRITE && wh |-> PRDATA[10:8] == ALARM_VALUE[8:6])
		else $error("wh read");
	c_locked: cover property (acc && PWRITE && !CLOCK_WRITE_ENABLE);
	c_md_wr: cover property (wen && md);
	c_wh_rd: cover property (acc && !PWRITE && wh);
endmodule : ravr_alarm_regs_props
bind ravr_alarm_regs ravr_alarm_regs_props u_props (.*);

//--- rtc_alarm_value_regs_test.sv
`timescale 1ns/10ps
module rtc_alarm_value_regs_test;
	import ravr_pkg::*;
	logic SYS_CLK = 1'h0, ARST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
	logic PREADY, PSLVERR, CLOCK_WRITE_ENABLE, ALARM_MATCH;
	logic [11:0] PADDR = 12'h0, a;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd, d, last;
	logic [3:0] PSTRB = 4'h3;
	logic err;
	ravr_alarm_t CAL_NOW = '0, ALARM_VALUE, exp_al;
	integer seed = 32'hf3bc0d96, n_errors = 0, samples_checked = 0, cycles = 0, i;
	always #50 SYS_CLK = ~SYS_CLK;
	ravr_alarm_regs u_ravr_alarm_regs (
		.SYS_CLK(SYS_CLK),
		.ARST_N(ARST_N),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PSTRB(PSTRB),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.CAL_NOW(CAL_NOW),
		.ALARM_VALUE(ALARM_VALUE),
		.CLOCK_WRITE_ENABLE(CLOCK_WRITE_ENABLE),
		.ALARM_MATCH(ALARM_MATCH)
	);
	function automatic logic [31:0] fold(input logic [11:0] ad, input logic [31:0] dv);
		return {16'h0, dv[15:0] & (ad == OFS_MONTH_DAY ? MASK_MONTH_DAY : MASK_WEEKDAY_HOUR)};
	endfunction : fold
	task end_of_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	task apb(input logic wr, input logic [11:0] ad, input logic [31:0] dv);
		PSEL <= 1'h1;
		PWRITE <= wr;
		PADDR <= ad;
		PWDATA <= dv;
		@(posedge SYS_CLK);
		PENABLE <= 1'h1;
		do @(posedge SYS_CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge SYS_CLK);
	endtask : apb
	always @(posedge SYS_CLK)
		if (++cycles > 2000)
		begin
			n_errors++;
			end_of_test;
		end
	initial
	begin
		repeat (10) @(posedge SYS_CLK);
		ARST_N <= 1'h1;
		@(posedge SYS_CLK);
		apb(1'h1, OFS_MONTH_DAY, 32'hffffffff);
		apb(1'h0, OFS_MONTH_DAY, 32'h0);
		check(rd, 32'h0);
		apb(1'h1, OFS_CONTROL, 32'h1);
		for (i = 0; i < 40; i++)
		begin
			a = i[0] ? OFS_WEEKDAY_HOUR : OFS_MONTH_DAY;
			d = i < 2 ? 32'hffffffff : $random(seed);
			apb(1'h1, a, d);
			apb(1'h0, a, 32'h0);
			check(rd, fold(a, d));
			last = fold(a, d);
		end
		check(CLOCK_WRITE_ENABLE, 32'h1);
		apb(1'h1, OFS_MONTH_DAY, 32'h0000_1229);
		apb(1'h1, OFS_WEEKDAY_HOUR, 32'h0000_0623);
		last = 32'h0000_0623;
		exp_al.month_day = '{1'h1, 4'h2, 2'h2, 4'h9};
		exp_al.weekday_hour = '{3'h6, 2'h2, 4'h3};
		check(ALARM_VALUE, exp_al);
		CAL_NOW <= exp_al;
		repeat (2) @(posedge SYS_CLK);
		check(ALARM_MATCH, 32'h1);
		apb(1'h0, OFS_STATUS, 32'h0);
		check(rd, 32'h7);
		CAL_NOW <= '0;
		apb(1'h1, OFS_STATUS, 32'h2);
		apb(1'h0, OFS_STATUS, 32'h0);
		check(rd, 32'h1);
		check(ALARM_MATCH, 32'h0);
		PSTRB <= 4'h1;
		apb(1'h1, OFS_MONTH_DAY, 32'h0);
		PSTRB <= 4'h3;
		apb(1'h0, OFS_MONTH_DAY, 32'h0);
		check(rd, 32'h1200);
		apb(1'h0, 12'h010, 32'h0);
		check(err, 32'h1);
		check(rd, 32'h0);
		apb(1'h1, OFS_CONTROL, 32'h0);
		check(CLOCK_WRITE_ENABLE, 32'h0);
		apb(1'h1, OFS_WEEKDAY_HOUR, 32'h0);
		apb(1'h0, OFS_WEEKDAY_HOUR, 32'h0);
		check(rd, last);
		ARST_N <= 1'h0;
		@(posedge SYS_CLK);
		check(ALARM_VALUE, 32'h0);
		ARST_N <= 1'h1;
		@(posedge SYS_CLK);
		apb(1'h0, OFS_CONTROL, 32'h0);
		check(rd, 32'h0);
		end_of_test;
	end
endmodule : rtc_alarm_value_regs_test
